/* sim/rail_model.sv */
`timescale 1ns/1ps
// analog side: each output climbs some cycles after its enable and collapses when disabled
module rail_model #(
  parameter int RISE = 20
) (
  input wire logic clk, // oscillator clock
  input wire logic rst_b, // async reset, active low
  input wire logic main_conv_en, // main converter enable
  input wire logic [3:0] lin_reg_en, // regulator enables
  input wire logic [4:0] droop, // bench-commanded sag per output
  output logic [4:0] out_above_92, // upper comparator per output
  output logic [4:0] out_below_90 // lower comparator per output
);
  logic [4:0] en;
  logic [7:0] cnt_ff [5];
  assign en = {lin_reg_en, main_conv_en};
  // lower comparator clears before the upper one, as real hysteresis does
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 5; i++) cnt_ff[i] <= 8'h00;
      out_above_92 <= 5'h00;
      out_below_90 <= 5'h1f;
    end else begin
      for (int i = 0; i < 5; i++) begin
        cnt_ff[i] <= !en[i] ? 8'h00 : (cnt_ff[i] < RISE) ? cnt_ff[i] + 8'h01 : cnt_ff[i];
        out_above_92[i] <= en[i] && (cnt_ff[i] >= RISE - 1) && !droop[i];
        out_below_90[i] <= !en[i] || (cnt_ff[i] < RISE - 3) || droop[i];
      end
    end
  end
endmodule

/* sim/tb_supply_startup_sequencer.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_supply_startup_sequencer;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic rail_ok = 1'b0;
  logic rail_short = 1'b0;
  logic ref_ok = 1'b0;
  logic bias_ok = 1'b0;
  logic thermal_hot = 1'b0;
  logic tracking_mode = 1'b0;
  logic fb_gnd = 1'b0;
  logic lim_rail = 1'b0;
  logic [4:0] droop = 5'h00;
  logic [4:0] above, below;
  logic switching_en, main_conv_en, ss_done, gate_force_low, pg_o, pg_oe, preset_sel, def_lim;
  logic [3:0] lin_reg_en;
  logic [6:0] ss_dac_code;
  logic a, b;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int sel;
  integer seed = 82;

  always #2 clk = ~clk;

  supply_startup_sequencer dut_u (.clk(clk), .rst_b(rst_b), .ce(ce),
    .internal_5v_rail_ok(rail_ok), .internal_5v_rail_short(rail_short), .ref_ok(ref_ok),
    .bias_ok(bias_ok), .thermal_hot(thermal_hot), .tracking_mode(tracking_mode),
    .out_above_92(above), .out_below_90(below), .main_feedback_grounded(fb_gnd),
    .limit_setting_at_rail(lim_rail), .switching_en(switching_en),
    .main_conv_en(main_conv_en), .lin_reg_en(lin_reg_en), .ss_dac_code(ss_dac_code),
    .ss_done(ss_done), .gate_force_low(gate_force_low), .power_good_flag_o(pg_o),
    .power_good_flag_oe(pg_oe), .preset_select(preset_sel), .default_limit_select(def_lim));

  rail_model #(.RISE(20)) model_u (.clk(clk), .rst_b(rst_b), .main_conv_en(main_conv_en),
    .lin_reg_en(lin_reg_en), .droop(droop), .out_above_92(above), .out_below_90(below));

  task automatic give_verdict;
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // two ramps plus traffic fit well inside this ceiling
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // expected dac code n cycles into the ramp
  function automatic logic [6:0] dac_at(input int n);
    return 7'(n / 16);
  endfunction

  // force a restart from off, then raise every condition in the chosen mode
  task automatic start(input logic mode);
    @(posedge clk);
    ref_ok <= 1'b0;
    tick(2);
    @(posedge clk);
    ref_ok <= 1'b1;
    rail_ok <= 1'b1;
    bias_ok <= 1'b1;
    thermal_hot <= 1'b0;
    tracking_mode <= mode;
    for (int i = 0; i < 4 && switching_en !== 1'b1; i++) tick(1);
    `CHK("switching_en", 1'b1, switching_en)
  endtask

  initial begin
    tick(10);
    `CHK("gate_force_low", 1'b1, gate_force_low)
    `CHK("pg_oe", 1'b1, pg_oe)
    `CHK("pg_o", 1'b0, pg_o)
    @(posedge clk);
    rst_b <= 1'b1;
    // sequencing ramp: main output is already good while the ramp runs
    start(1'b0);
    `CHK("main_conv_en", 1'b1, main_conv_en)
    for (int m = 2; m <= 1025; m++) begin
      tick(1);
      `CHK("lin_reg_en", 4'h0, lin_reg_en)
      if (m % 16 == 8) `CHK("ss_dac_code", dac_at(m), ss_dac_code)
      if (m == 1024) `CHK("ss_done", 1'b0, ss_done)
    end
    `CHK("ss_done", 1'b1, ss_done)
    `CHK("ss_dac_code", 7'h40, ss_dac_code)
    `CHK("gate_force_low", 1'b0, gate_force_low)
    tick(1);
    `CHK("lin_reg_en", 4'h1, lin_reg_en)
    tick(8);
    `CHK("lin_reg_en", 4'h1, lin_reg_en)
    for (int i = 0; i < 40 && lin_reg_en !== 4'h3; i++) tick(1);
    `CHK("lin_reg_en", 4'h3, lin_reg_en)
    `CHK("pg_oe", 1'b1, pg_oe)
    for (int i = 0; i < 40 && pg_oe !== 1'b0; i++) tick(1);
    `CHK("pg_oe", 1'b0, pg_oe)
    `CHK("above", 3'h7, above[2:0])
    // one monitored output sags, then recovers
    @(posedge clk);
    droop <= 5'(5'h01 << ($unsigned($random(seed)) % 3));
    tick(2);
    `CHK("pg_oe", 1'b1, pg_oe)
    @(posedge clk);
    droop <= 5'h00;
    for (int i = 0; i < 10 && pg_oe !== 1'b0; i++) tick(1);
    `CHK("pg_oe", 1'b0, pg_oe)
    // hot junction is ignored while the rail is shorted
    @(posedge clk);
    rail_short <= 1'b1;
    thermal_hot <= 1'b1;
    tick(4);
    `CHK("switching_en", 1'b1, switching_en)
    @(posedge clk);
    rail_short <= 1'b0;
    tick(1);
    `CHK("gate_force_low", 1'b1, gate_force_low)
    `CHK("outputs", 5'h00, {lin_reg_en, main_conv_en})
    // ramp clears one edge after switching stops
    tick(1);
    `CHK("ss_done", 1'b0, ss_done)
    `CHK("ss_dac_code", 7'h00, ss_dac_code)
    `CHK("pg_oe", 1'b1, pg_oe)
    @(posedge clk);
    thermal_hot <= 1'b0;
    for (int i = 0; i < 4 && switching_en !== 1'b1; i++) tick(1);
    `CHK("switching_en", 1'b1, switching_en)
    `CHK("lin_reg_en", 4'h0, lin_reg_en)
    // random loss of one enable condition
    for (int k = 0; k < 4; k++) begin
      sel = $unsigned($random(seed)) % 3;
      @(posedge clk);
      if (sel == 0) rail_ok <= 1'b0;
      else if (sel == 1) ref_ok <= 1'b0;
      else bias_ok <= 1'b0;
      tick(1);
      `CHK("switching_en", 1'b0, switching_en)
      `CHK("pg_oe", 1'b1, pg_oe)
      if (sel == 0) `CHK("gate_force_low", 1'b1, gate_force_low)
      tick(3);
      `CHK("main_conv_en", 1'b0, main_conv_en)
      start(1'b0);
      `CHK("ss_dac_code", 7'h00, ss_dac_code)
    end
    // tracking: everything on together, power-good waits on all five
    start(1'b1);
    `CHK("lin_reg_en", 4'hf, lin_reg_en)
    `CHK("main_conv_en", 1'b1, main_conv_en)
    @(posedge clk);
    droop <= 5'h10;
    for (int i = 0; i < 1100 && ss_done !== 1'b1; i++) tick(1);
    `CHK("ss_done", 1'b1, ss_done)
    tick(4);
    `CHK("pg_oe", 1'b1, pg_oe)
    @(posedge clk);
    droop <= 5'h00;
    for (int i = 0; i < 10 && pg_oe !== 1'b0; i++) tick(1);
    `CHK("pg_oe", 1'b0, pg_oe)
    // clock enable low freezes the sequencer even when the reference drops
    @(posedge clk);
    ce <= 1'b0;
    ref_ok <= 1'b0;
    tick(3);
    `CHK("switching_en", 1'b1, switching_en)
    `CHK("pg_oe", 1'b0, pg_oe)
    @(posedge clk);
    ce <= 1'b1;
    tick(1);
    `CHK("switching_en", 1'b0, switching_en)
    @(posedge clk);
    ref_ok <= 1'b1;
    // mid-run lockout reset clears everything, then tracking restarts
    @(posedge clk);
    rst_b <= 1'b0;
    tick(1);
    `CHK("main_conv_en", 1'b0, main_conv_en)
    `CHK("gate_force_low", 1'b1, gate_force_low)
    `CHK("pg_oe", 1'b1, pg_oe)
    @(posedge clk);
    rst_b <= 1'b1;
    tick(2);
    `CHK("lin_reg_en", 4'hf, lin_reg_en)
    // straps follow their pins one cycle late
    for (int k = 0; k < 6; k++) begin
      a = 1'($random(seed));
      b = 1'($random(seed));
      @(posedge clk);
      fb_gnd <= a;
      lim_rail <= b;
      tick(2);
      `CHK("preset_select", a, preset_sel)
      `CHK("default_limit_select", b, def_lim)
    end
    give_verdict();
  end
endmodule

/* src/soft_start_ramp.sv */
`timescale 1ns/1ps
`include "supply_seq_defs.svh"
module soft_start_ramp #(
  parameter int SS_CYCLES = `SS_CYCLES,
  parameter int SS_STEPS = `SS_STEPS
) (
  input wire logic clk, // oscillator clock
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic run, // ramp runs while high, clears when low
  output logic [$clog2(SS_STEPS):0] dac_code, // target, 0..SS_STEPS
  output logic done // ramp complete
);
  localparam int CW = $clog2(SS_CYCLES);
  localparam int DW = $clog2(SS_STEPS) + 1;
  localparam int STEP = SS_CYCLES / SS_STEPS;
  localparam int SW = $clog2(STEP);

  initial begin
    if (SS_CYCLES != SS_STEPS * STEP || (1 << SW) != STEP || STEP < 2)
      $error("soft_start_ramp: cycles must be a power-of-two multiple of steps");
  end

  logic [CW-1:0] cnt_ff;
  logic done_ff;
  logic [DW-1:0] dac_ff;
  wire last_cycle = (cnt_ff == CW'(SS_CYCLES - 1));
  wire [CW-1:0] nxt_cnt = (!run || done_ff) ? '0 : cnt_ff + CW'(1);
  wire nxt_done = run && (done_ff || last_cycle);
  // one dac step per STEP cycles, full scale only once the ramp ends
  wire [DW-1:0] nxt_dac = !run ? '0 :
                          nxt_done ? DW'(SS_STEPS) :
                          DW'(nxt_cnt >> SW);

  // counting restarts from zero whenever run drops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
      dac_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      dac_ff <= nxt_dac;
    end
  end

  assign dac_code = dac_ff;
  assign done = done_ff;

  // full scale is reached only from the last ramp step
  dac_last_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(done_ff) |-> $past(dac_ff) == DW'(SS_STEPS - 1))
    else $error("ramp ended without passing the last step");

  // step changes happen only on step boundaries
  dac_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && run && !done_ff && dac_ff != nxt_dac && !nxt_done) |->
      nxt_cnt[SW-1:0] == '0)
    else $error("dac stepped off a step boundary");
endmodule

/* src/supply_seq_defs.svh */
`ifndef SUPPLY_SEQ_DEFS_SVH
`define SUPPLY_SEQ_DEFS_SVH
// soft-start length in oscillator cycles and dac step count
`define SS_CYCLES 1024
`define SS_STEPS 64
// monitored outputs: sequencing watches three, tracking watches five
`define NUM_OUTPUTS 5
`define MON_MASK_SEQ 5'h07
`define MON_MASK_TRK 5'h1f
// linear regulator enable patterns
`define LIN_NONE 4'h0
`define LIN_FIRST 4'h1
`define LIN_FIRST_SECOND 4'h3
`define LIN_ALL 4'hf
// monitor bit positions
`define MON_MAIN 0
`define MON_FIRST 1
`define MON_SECOND 2
`endif

/* src/supply_seq_pkg.sv */
package supply_seq_pkg;
  // gray codes along off -> main -> first -> second; tracking branches off
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_MAIN = 3'h1,
    ST_FIRST = 3'h3,
    ST_SECOND = 3'h2,
    ST_TRACK = 3'h6
  } seq_state_t;
endpackage

/* src/supply_startup_sequencer.sv */
// Summary of operation
// - internal enable needs rail ok, reference ok, bias up, no thermal limit
// - switching and soft-start both begin when the internal enable asserts
// - soft-start lasts 1024 oscillator cycles from start of switching
// - soft-start dac climbs in 64 equal steps to the reference
// - sequencing: main converter first with soft-start, regulators off
// - sequencing: first regulator after main feedback ok and ramp done
// - sequencing: second regulator after first regulator feedback ok
// - sequencing: power-good only when all three outputs are above 92%
// - tracking: main converter and all four regulators enabled together
// - tracking: power-good only when all five outputs are above 92%
// - open-drain power-good pulls low when any monitored output drops below 90%
// - power-good released only with all monitored outputs above 92% and ramp done
// - over-temperature shuts down and forces both gate drives low
// - operation resumes once the thermal indication clears
// - thermal event disables outputs, pulls power-good low, resets ramp
// - thermal protection is ignored while the 5v rail is shorted
// - grounded main feedback selects preset 3.3v sensing
// - limit input at the 5v rail selects default valley threshold
// - rail below 3.5v stops switching, holds power-good low, gates low
`timescale 1ns/1ps
`include "supply_seq_defs.svh"
module supply_startup_sequencer #(
  parameter int SS_CYCLES = `SS_CYCLES,
  parameter int SS_STEPS = `SS_STEPS,
  parameter int NUM_OUT = `NUM_OUTPUTS
) (
  input wire logic clk, // internal oscillator clock
  input wire logic rst_b, // supply_lockout reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic internal_5v_rail_ok, // rail above 3.5v
  input wire logic internal_5v_rail_short, // rail output shorted
  input wire logic ref_ok, // reference above 92%
  input wire logic bias_ok, // bias circuitry up
  input wire logic thermal_hot, // junction over limit
  input wire logic tracking_mode, // 1 tracking, 0 sequencing
  input wire logic [NUM_OUT-1:0] out_above_92, // per-output upper comparator
  input wire logic [NUM_OUT-1:0] out_below_90, // per-output lower comparator
  input wire logic main_feedback_grounded, // main_feedback tied to ground
  input wire logic limit_setting_at_rail, // limit_setting_input at rail
  output logic switching_en, // step-down converter switching
  output logic main_conv_en, // main converter enabled
  output logic [3:0] lin_reg_en, // linear regulator enables
  output logic [$clog2(SS_STEPS):0] ss_dac_code, // soft-start target
  output logic ss_done, // soft-start complete
  output logic gate_force_low, // low_side and high_side gate drives low
  output logic power_good_flag_o, // open-drain data, always low
  output logic power_good_flag_oe, // high while pulling pin low
  output logic preset_select, // regulate preset 3.3v via sense input
  output logic default_limit_select // default 250mv valley threshold
);
  localparam int DW = $clog2(SS_STEPS) + 1;

  initial begin
    if (NUM_OUT != `NUM_OUTPUTS)
      $error("supply_startup_sequencer: monitor count must be five");
  end

  supply_seq_pkg::seq_state_t state_ff, nxt_state;
  logic switch_ff;
  logic main_ff;
  logic [3:0] lin_ff;
  logic gate_low_ff;
  logic pg_ok_ff;
  logic pg_data_ff;
  logic pg_pull_ff;
  logic preset_ff;
  logic deflim_ff;
  logic [DW-1:0] dac_code;
  logic ramp_done;

  // thermal sensing is ignored while the rail is shorted
  wire thermal_active = thermal_hot && !internal_5v_rail_short;
  // all four start conditions must hold together
  wire enable_ok = internal_5v_rail_ok && ref_ok && bias_ok &&
                   !thermal_active;

  // ramp runs only while enabled, so any enable loss resets it
  soft_start_ramp #(
    .SS_CYCLES(SS_CYCLES),
    .SS_STEPS(SS_STEPS)
  ) u_ramp (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .run(switch_ff),
    .dac_code(dac_code),
    .done(ramp_done)
  );

  // sequence steps
  wire main_ready = out_above_92[`MON_MAIN] && ramp_done;
  wire first_ready = out_above_92[`MON_FIRST];

  always_comb begin
    nxt_state = state_ff;
    if (!enable_ok) begin
      nxt_state = supply_seq_pkg::ST_OFF;
    end else begin
      unique case (state_ff)
        supply_seq_pkg::ST_OFF: begin
          nxt_state = tracking_mode ? supply_seq_pkg::ST_TRACK :
                      supply_seq_pkg::ST_MAIN;
        end
        supply_seq_pkg::ST_MAIN: begin
          if (main_ready)
            nxt_state = supply_seq_pkg::ST_FIRST;
        end
        supply_seq_pkg::ST_FIRST: begin
          if (first_ready)
            nxt_state = supply_seq_pkg::ST_SECOND;
        end
        supply_seq_pkg::ST_SECOND: nxt_state = supply_seq_pkg::ST_SECOND;
        supply_seq_pkg::ST_TRACK: nxt_state = supply_seq_pkg::ST_TRACK;
        default: nxt_state = supply_seq_pkg::ST_OFF;
      endcase
    end
  end

  // regulator enables decoded from the next state
  wire nxt_main = (nxt_state != supply_seq_pkg::ST_OFF);
  wire [3:0] nxt_lin =
    (nxt_state == supply_seq_pkg::ST_TRACK) ? `LIN_ALL :
    (nxt_state == supply_seq_pkg::ST_SECOND) ? `LIN_FIRST_SECOND :
    (nxt_state == supply_seq_pkg::ST_FIRST) ? `LIN_FIRST : `LIN_NONE;

  // power-good monitor window depends on mode
  wire [NUM_OUT-1:0] mon_mask = tracking_mode ? `MON_MASK_TRK : `MON_MASK_SEQ;
  wire all_high = &(out_above_92 | ~mon_mask);
  wire any_low = |(out_below_90 & mon_mask);
  wire seq_settled = (state_ff == supply_seq_pkg::ST_SECOND) ||
                     (state_ff == supply_seq_pkg::ST_TRACK);
  // 90/92 split gives hysteresis: hold while none below 90
  wire nxt_pg_ok = enable_ok && seq_settled &&
                   (pg_ok_ff ? !any_low : (all_high && ramp_done));

  // gate drives held low in lockout and thermal shutdown
  wire nxt_gate_low = !internal_5v_rail_ok || thermal_active;

  // sequencer state and enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= supply_seq_pkg::ST_OFF;
      switch_ff <= 1'b0;
      main_ff <= 1'b0;
      lin_ff <= `LIN_NONE;
    end else if (ce) begin
      state_ff <= nxt_state;
      switch_ff <= enable_ok;
      main_ff <= nxt_main;
      lin_ff <= nxt_lin;
    end
  end

  // pin and strap outputs; straps are followed, never latched at reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_low_ff <= 1'b1;
      pg_ok_ff <= 1'b0;
      pg_data_ff <= 1'b0;
      pg_pull_ff <= 1'b1;
      preset_ff <= 1'b0;
      deflim_ff <= 1'b1;
    end else if (ce) begin
      gate_low_ff <= nxt_gate_low;
      pg_ok_ff <= nxt_pg_ok;
      // pin enable kept in its own flop so the port needs no gate after it
      pg_pull_ff <= !nxt_pg_ok;
      pg_data_ff <= 1'b0;
      preset_ff <= main_feedback_grounded;
      deflim_ff <= limit_setting_at_rail;
    end
  end

  assign switching_en = switch_ff;
  assign main_conv_en = main_ff;
  assign lin_reg_en = lin_ff;
  assign ss_dac_code = dac_code;
  assign ss_done = ramp_done;
  assign gate_force_low = gate_low_ff;
  assign power_good_flag_o = pg_data_ff;
  assign power_good_flag_oe = pg_pull_ff;
  assign preset_select = preset_ff;
  assign default_limit_select = deflim_ff;

  // named steps of the startup
  sequence start_req_s;
    ce && rst_b && enable_ok && state_ff == supply_seq_pkg::ST_OFF;
  endsequence
  sequence ramp_begin_s;
    switching_en && main_conv_en && ss_dac_code == '0;
  endsequence
  // power-good release as one named step
  sequence pg_up_s;
    $fell(power_good_flag_oe);
  endsequence
  // enable loss seen on an active edge
  sequence shut_s;
    ce && !enable_ok;
  endsequence

  start_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !enable_ok) |=> !switching_en && !main_conv_en)
    else $error("enabled without all start conditions");

  ramp_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    start_req_s |=> ramp_begin_s)
    else $error("switching and ramp did not start together");

  ramp_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    (start_req_s ##1 ce [*8]) |-> !ss_done)
    else $error("ramp completed far too early");

  seq_first_a: assert property (@(posedge clk) disable iff (!rst_b)
    (start_req_s and !tracking_mode) |=> main_conv_en && lin_reg_en == `LIN_NONE)
    else $error("sequencing did not start with main only");

  first_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(lin_reg_en[0]) && lin_reg_en != `LIN_ALL) |->
      $past(out_above_92[`MON_MAIN]) && $past(ss_done))
    else $error("first regulator enabled too soon");

  second_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(lin_reg_en[1]) && lin_reg_en != `LIN_ALL) |->
      $past(out_above_92[`MON_FIRST]) && $past(lin_reg_en[0]))
    else $error("second regulator enabled too soon");

  track_all_a: assert property (@(posedge clk) disable iff (!rst_b)
    (start_req_s and tracking_mode) |=> main_conv_en && lin_reg_en == `LIN_ALL)
    else $error("tracking did not enable all outputs");

  pg_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(power_good_flag_oe) |-> $past(all_high) && $past(ss_done))
    else $error("power-good released without all outputs up");

  pg_pull_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && any_low) |=> power_good_flag_oe)
    else $error("power-good not pulled low on output drop");

  thermal_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && thermal_active) |=> gate_force_low && power_good_flag_oe &&
      lin_reg_en == `LIN_NONE && !main_conv_en)
    else $error("thermal event did not shut down");

  lockout_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !internal_5v_rail_ok) |=> !switching_en && gate_force_low &&
      power_good_flag_oe)
    else $error("lockout did not stop the converter");

  short_ignore_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && internal_5v_rail_short && internal_5v_rail_ok && ref_ok && bias_ok)
      |=> switching_en)
    else $error("thermal acted while rail shorted");

  strap_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && rst_b) |=> preset_select == $past(main_feedback_grounded) &&
      default_limit_select == $past(limit_setting_at_rail))
    else $error("strap selection not followed");

  // release in sequencing needs the three watched outputs up
  pg_seq_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    pg_up_s |-> $past(&out_above_92[`MON_SECOND:`MON_MAIN]))
    else $error("power-good released with a sequenced output low");

  // release in tracking needs all five outputs up
  pg_track_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    pg_up_s |-> $past(!tracking_mode || &out_above_92))
    else $error("power-good released with a tracked output low");

  // release only once the sequence has settled
  pg_settled_a: assert property (@(posedge clk) disable iff (!rst_b)
    pg_up_s |-> $past(seq_settled))
    else $error("power-good released before the sequence settled");

  // open-drain data never drives the pin high
  pg_data_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    !power_good_flag_o)
    else $error("power-good data driven high");

  // switching and the main converter always move together
  switch_main_a: assert property (@(posedge clk) disable iff (!rst_b)
    switching_en == main_conv_en)
    else $error("switching and main enable disagree");

  // sequenced regulators stay off until the ramp is done
  lin_after_ramp_a: assert property (@(posedge clk) disable iff (!rst_b)
    (lin_reg_en != `LIN_NONE && lin_reg_en != `LIN_ALL) |-> ss_done)
    else $error("regulator on before soft-start completed");

  // second regulator never runs without the first
  second_order_a: assert property (@(posedge clk) disable iff (!rst_b)
    (lin_reg_en != `LIN_ALL) |->
      lin_reg_en inside {`LIN_NONE, `LIN_FIRST, `LIN_FIRST_SECOND})
    else $error("regulators enabled out of order");

  // full scale only once the ramp has ended
  dac_full_a: assert property (@(posedge clk) disable iff (!rst_b)
    ss_done |-> ss_dac_code == DW'(SS_STEPS))
    else $error("ramp done below full scale");

  // ramp returns to zero one edge after switching stops
  ramp_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !switching_en) |=> ss_dac_code == '0 && !ss_done)
    else $error("ramp not cleared while stopped");

  // restart as soon as the hot flag clears
  resume_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && rst_b && $fell(thermal_active) && enable_ok) |=> switching_en)
    else $error("no restart after cooling");

  // any enable loss sends the sequencer back to the start
  restart_a: assert property (@(posedge clk) disable iff (!rst_b)
    shut_s |=> state_ff == supply_seq_pkg::ST_OFF && lin_reg_en == `LIN_NONE)
    else $error("enable loss did not restart the sequence");

  // gates are freed once the rail is good and the junction cool
  gate_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && rst_b && internal_5v_rail_ok && !thermal_active) |=> !gate_force_low)
    else $error("gate drives held low without cause");

  // default limit follows its strap
  limit_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && rst_b && limit_setting_at_rail) |=> default_limit_select)
    else $error("default limit not selected");

  // divider mode whenever feedback is not grounded
  preset_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && rst_b && !main_feedback_grounded) |=> !preset_select)
    else $error("preset selected with feedback not grounded");

  // tracking keeps every output enabled
  track_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == supply_seq_pkg::ST_TRACK) |-> lin_reg_en == `LIN_ALL && main_conv_en)
    else $error("tracking state without all outputs");

  // a low clock enable freezes the start decision and the ramp
  freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(state_ff) && $stable(switching_en) && $stable(ss_dac_code))
    else $error("state moved with clock enable low");

  // usual path steps change one state bit at a time
  gray_path_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && rst_b && enable_ok && state_ff != supply_seq_pkg::ST_OFF) |=>
      $countones(state_ff ^ $past(state_ff)) <= 1)
    else $error("state moved by more than one bit");
endmodule
